// ===== src/fcsp_core.sv
/*
  Flash command, status and protection logic: AHB-Lite register slave,
  protection register loaded from an image, command launch, queue for
  burst programs, error flags and the program/erase clock divider.
  Assumes the flash array reports blank state and that reset holds the
  protection image steady; the array model itself lives outside.
*/
// What this block does
// - config bits 7:5 writable, 4:0 read zero
// - key write enable steers key window writes
// - protection register loaded from image on first edge after reset
// - writes only lower boundary; disabled means unchanged
// - boundary sets unprotected end; protected targets refused
// - protection off bit disables all block protection
// - status bits 3,1,0 read zero, ignore writes
// - write one to buffer empty launches command
// - only burst programs may be queued
// - complete flag set when idle, cleared on launch
// - protected target sets violation, write one clears
// - sequence, no divider, stop entry set error
// - access error clears on one, zero keeps
// - blank flag set by erased check, cleared on launch
// - decode five command codes
// - other codes rejected with access error
// - flash clock is bus, prescaled, divided ratio+1
// - erased check or key match unsecures device
`timescale 1ns/1ps
`default_nettype none
module fcsp_core
  import fcsp_pkg::*;
(
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // flash array side
  input  wire logic [7:0]  nvProtectImage,
  input  wire logic        arrayErased,
  input  wire logic        keyMatch,
  input  wire logic        stopEntry,
  output logic             keyWriteStrobe,
  output logic [15:0]      keyWriteAddr,
  output logic [7:0]       keyWriteData,
  output logic             flashClkPulse,
  output logic             opActive,
  output logic [7:0]       opCode,
  output logic [15:0]      opAddr,
  output logic [7:0]       opData,
  output logic [1:0]       securityStateCode
);
  import fcsp_pkg::*;

  // address phase capture
  logic        wrPend_q, rdPend_q;
  logic [7:0]  regOfs_q;
  logic        inited_q;
  wire         addrTake = hsel & hready & htrans[1];

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wrPend_q <= 1'b0;
      rdPend_q <= 1'b0;
      regOfs_q <= 8'h00;
    end else begin
      wrPend_q <= addrTake & hwrite;
      rdPend_q <= addrTake & ~hwrite;
      regOfs_q <= addrTake ? haddr[7:0] : regOfs_q;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // register write decode
  wire wrCfg    = wrPend_q & (regOfs_q == OFS_CONFIG);
  wire wrProt   = wrPend_q & (regOfs_q == OFS_PROTECT);
  wire wrStat   = wrPend_q & (regOfs_q == OFS_STATUS);
  wire wrCmd    = wrPend_q & (regOfs_q == OFS_COMMAND);
  wire wrRatio  = wrPend_q & (regOfs_q == OFS_RATIO);
  wire wrAddr   = wrPend_q & (regOfs_q == OFS_ADDR);
  wire wrData   = wrPend_q & (regOfs_q == OFS_DATA);
  wire [7:0] wb = hwdata[7:0];

  // registers
  logic [7:0]  cfg_q;
  logic [7:0]  prot_q;
  logic [6:0]  ratio_q;
  logic        ratioSet_q;
  logic [7:0]  cmd_q;
  logic [15:0] addr_q;
  logic [7:0]  data_q;
  logic        cbe_q, pv_q, ae_q, blank_q;
  logic [1:0]  sec_q;

  wire keyEnable = cfg_q[CFG_KEY_BIT];

  // config: upper three bits only
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) cfg_q <= CFG_RESET;
    else if (wrCfg) cfg_q <= wb & CFG_LIVE_MASK;
  end

  // protection: image captured on the first edge after release
  wire [6:0] newBound  = wb[7:1];
  wire       lowerOnly = newBound < prot_q[7:1];
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      prot_q   <= 8'hFF;
      inited_q <= 1'b0;
    end else if (!inited_q) begin
      prot_q   <= nvProtectImage;
      inited_q <= 1'b1;
    end else if (wrProt && !prot_q[PROT_OFF_BIT] && lowerOnly) begin
      prot_q[7:1] <= newBound;
    end
  end

  // address and data latches; key window writes go out as key bytes
  wire inKeyWin = (hwdata[31:16] >= KEY_WIN_LO) & (hwdata[31:16] <= KEY_WIN_HI);
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      addr_q         <= 16'h0000;
      data_q         <= 8'h00;
      keyWriteStrobe <= 1'b0;
      keyWriteAddr   <= 16'h0000;
      keyWriteData   <= 8'h00;
    end else begin
      keyWriteStrobe <= wrAddr & keyEnable & inKeyWin;
      keyWriteAddr   <= hwdata[31:16];
      keyWriteData   <= wb;
      if (wrAddr && !(keyEnable && inKeyWin)) begin
        addr_q <= hwdata[31:16];
        data_q <= wb;
      end else if (wrData) begin
        data_q <= wb;
      end
    end
  end

  // clock ratio register: written once marks divider as set
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ratio_q    <= RATIO_RESET;
      ratioSet_q <= 1'b0;
    end else if (wrRatio) begin
      ratio_q    <= wb[6:0];
      ratioSet_q <= 1'b1;
    end
  end

  // flash clock divider: optional /8, then /(ratio+1)
  logic [2:0] pre_q;
  logic [5:0] div_q;
  wire preTick = ~ratio_q[RATIO_PRE8_BIT] | (pre_q == 3'h7);
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pre_q         <= 3'h0;
      div_q         <= 6'h00;
      flashClkPulse <= 1'b0;
    end else begin
      pre_q         <= pre_q + 3'h1;
      flashClkPulse <= preTick & (div_q == ratio_q[5:0]);
      if (preTick) div_q <= (div_q == ratio_q[5:0]) ? 6'h00 : div_q + 6'h01;
    end
  end

  // command decode
  function automatic logic cmdKnown(input logic [7:0] c);
    cmdKnown = (c == CMD_BLANK) | (c == CMD_BYTE) | (c == CMD_BURST) |
               (c == CMD_PAGE) | (c == CMD_MASS);
  endfunction
  function automatic logic cmdWrites(input logic [7:0] c);
    cmdWrites = (c == CMD_BYTE) | (c == CMD_BURST) | (c == CMD_PAGE) |
                (c == CMD_MASS);
  endfunction

  // protected when enabled and address above boundary, or any mass erase while enabled
  wire [15:0] boundTop  = {prot_q[7:1], 9'h1FF};
  wire        protHit   = ~prot_q[PROT_OFF_BIT] &
                          ((addr_q > boundTop) | (cmd_q == CMD_MASS));

  // launch: write one to buffer-empty while it is set
  wire launchReq = wrStat & wb[ST_CBE_BIT] & cbe_q;
  fcsp_state_t st_q;
  logic        queued_q;
  logic [7:0]  pulses_q;
  wire running   = (st_q == FCSP_RUN);
  wire notBurst  = running & ((opCode != CMD_BURST) | (cmd_q != CMD_BURST));
  wire seqErr    = ~cmdKnown(cmd_q) | notBurst;
  wire noDivErr  = cmdWrites(cmd_q) & ~ratioSet_q;
  wire aeHit     = launchReq & (seqErr | noDivErr);
  wire pvHit     = launchReq & ~aeHit & cmdWrites(cmd_q) & protHit;
  wire goodLaunch = launchReq & ~aeHit & ~pvHit;
  wire stopErr   = stopEntry & running;
  wire opDone    = running & flashClkPulse & (pulses_q == OP_PULSES);
  wire startNow  = goodLaunch & ~running;

  // command register
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) cmd_q <= 8'h00;
    else if (wrCmd) cmd_q <= wb;
  end

  // array sequencer with one-deep burst queue
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q     <= FCSP_IDLE;
      queued_q <= 1'b0;
      pulses_q <= 8'h00;
      opCode   <= 8'h00;
      opAddr   <= 16'h0000;
      opData   <= 8'h00;
    end else begin
      case (st_q)
        FCSP_IDLE: begin
          pulses_q <= 8'h00;
          if (startNow) begin
            st_q   <= FCSP_RUN;
            opCode <= cmd_q;
            opAddr <= addr_q;
            opData <= data_q;
          end
        end
        FCSP_RUN: begin
          if (stopErr) begin
            st_q     <= FCSP_IDLE;
            queued_q <= 1'b0;
          end else if (goodLaunch) begin
            queued_q <= 1'b1;
          end else if (opDone && queued_q) begin
            queued_q <= 1'b0;
            pulses_q <= 8'h00;
            opAddr   <= addr_q;
            opData   <= data_q;
          end else if (opDone) begin
            st_q <= FCSP_IDLE;
          end else if (flashClkPulse) begin
            pulses_q <= pulses_q + 8'h01;
          end
        end
        default: st_q <= FCSP_IDLE;
      endcase
    end
  end

  // buffer empty: clears on launch, set again on the next cycle in which nothing is queued
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) cbe_q <= 1'b1;
    else if (goodLaunch) cbe_q <= 1'b0;
    else if (~queued_q & ~(startNow)) cbe_q <= 1'b1;
  end

  // error flags: set wins over write-one clear
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pv_q <= 1'b0;
      ae_q <= 1'b0;
    end else begin
      pv_q <= pvHit | (pv_q & ~(wrStat & wb[ST_PV_BIT]));
      ae_q <= aeHit | stopErr | (ae_q & ~(wrStat & wb[ST_AE_BIT]));
    end
  end

  // blank flag and security code
  wire blankOk = opDone & (opCode == CMD_BLANK) & arrayErased;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      blank_q <= 1'b0;
      sec_q   <= SEC_RESET;
    end else begin
      if (blankOk) blank_q <= 1'b1;
      else if (goodLaunch) blank_q <= 1'b0;
      if (blankOk || keyMatch) sec_q <= SEC_UNSECURED;
    end
  end

  wire ccFlag = cbe_q & ~running;
  assign opActive          = running;
  assign securityStateCode = sec_q;

  // read mux; unmapped offsets read zero
  wire [7:0] statRd = {cbe_q, ccFlag, pv_q, ae_q, 1'b0, blank_q, 2'b00};
  wire [7:0] rdByte =
    (regOfs_q == OFS_CONFIG)  ? cfg_q :
    (regOfs_q == OFS_PROTECT) ? prot_q :
    (regOfs_q == OFS_STATUS)  ? statRd :
    (regOfs_q == OFS_COMMAND) ? cmd_q :
    (regOfs_q == OFS_RATIO)   ? {ratioSet_q, ratio_q} :
    (regOfs_q == OFS_DATA)    ? data_q :
    (regOfs_q == OFS_SECURE)  ? {6'h00, sec_q} : 8'h00;
  wire [31:0] rdWord = (regOfs_q == OFS_ADDR) ? {addr_q, 16'h0000} : {24'h0, rdByte};
  assign hrdata = rdPend_q ? rdWord : 32'h0000_0000;

  // checks: register fields, protection, launch outcome, flags and divider
  a_cfg_low_zero: assert property (@(posedge ref_clk) disable iff (!rst_n)
    cfg_q[4:0] == 5'h00)
    else $error("config low bits not zero");
  a_key_strobe_win: assert property (@(posedge ref_clk) disable iff (!rst_n)
    wrAddr && keyEnable && inKeyWin |=> keyWriteStrobe && $stable(addr_q))
    else $error("key write not steered to key port");
  a_addr_latch: assert property (@(posedge ref_clk) disable iff (!rst_n)
    wrAddr && !keyEnable |=> !keyWriteStrobe && addr_q == keyWriteAddr)
    else $error("address write taken as key byte");
  a_prot_image: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !inited_q |=> prot_q == $past(nvProtectImage))
    else $error("protection image not loaded");
  a_prot_never_up: assert property (@(posedge ref_clk) disable iff (!rst_n)
    inited_q && $past(inited_q) |-> prot_q[7:1] <= $past(prot_q[7:1]))
    else $error("protection boundary raised");
  a_prot_off_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
    inited_q && prot_q[0] |=> prot_q == $past(prot_q))
    else $error("protection changed while off");
  a_prot_blocked: assert property (@(posedge ref_clk) disable iff (!rst_n)
    launchReq && !running && cmdWrites(cmd_q) && protHit |=> !running)
    else $error("protected target started");
  a_prot_off_run: assert property (@(posedge ref_clk) disable iff (!rst_n)
    launchReq && !running && prot_q[PROT_OFF_BIT] && cmdKnown(cmd_q) && ratioSet_q |=> running)
    else $error("command blocked with protection off");
  a_stat_zero: assert property (@(posedge ref_clk) disable iff (!rst_n)
    statRd[3] == 1'b0 && statRd[1:0] == 2'b00)
    else $error("status zero bits set");
  a_launch_clears: assert property (@(posedge ref_clk) disable iff (!rst_n)
    goodLaunch |=> !cbe_q && !ccFlag)
    else $error("launch did not clear flags");
  a_seq_refused: assert property (@(posedge ref_clk) disable iff (!rst_n)
    launchReq && running && opCode != CMD_BURST |=> ae_q && !queued_q)
    else $error("command queued behind non-burst");
  a_done_ends: assert property (@(posedge ref_clk) disable iff (!rst_n)
    opDone && !queued_q |=> !running ##1 ccFlag)
    else $error("complete not raised");
  a_viol_set: assert property (@(posedge ref_clk) disable iff (!rst_n)
    pvHit |=> pv_q && !$past(startNow))
    else $error("violation not flagged");
  a_stop_abort: assert property (@(posedge ref_clk) disable iff (!rst_n)
    stopErr |=> !running && ae_q)
    else $error("stop entry did not abort");
  a_nodiv_err: assert property (@(posedge ref_clk) disable iff (!rst_n)
    launchReq && !running && cmdWrites(cmd_q) && !ratioSet_q |=> ae_q && !running)
    else $error("command ran without divider");
  a_err_wr0_keep: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ae_q && wrStat && !wb[ST_AE_BIT] |=> ae_q)
    else $error("error cleared by zero");
  a_err_wr1_clear: assert property (@(posedge ref_clk) disable iff (!rst_n)
    wrStat && wb[ST_AE_BIT] && !aeHit && !stopErr |=> !ae_q)
    else $error("error not cleared by one");
  a_blank_sets: assert property (@(posedge ref_clk) disable iff (!rst_n)
    blankOk |=> blank_q && sec_q == SEC_UNSECURED)
    else $error("blank not recorded");
  a_blank_clear: assert property (@(posedge ref_clk) disable iff (!rst_n)
    goodLaunch && !blankOk |=> !blank_q)
    else $error("blank not cleared on launch");
  a_code_start: assert property (@(posedge ref_clk) disable iff (!rst_n)
    startNow |=> running && opCode == $past(cmd_q))
    else $error("started code differs");
  a_bad_code_err: assert property (@(posedge ref_clk) disable iff (!rst_n)
    launchReq && !cmdKnown(cmd_q) |=> ae_q && st_q == $past(st_q))
    else $error("illegal code not flagged");
  a_pulse_single: assert property (@(posedge ref_clk) disable iff (!rst_n)
    flashClkPulse && ratio_q[5:0] != 6'h00 |=> !flashClkPulse)
    else $error("flash clock pulse too long");
  a_key_unsecure: assert property (@(posedge ref_clk) disable iff (!rst_n)
    keyMatch |=> securityStateCode == SEC_UNSECURED)
    else $error("key match did not unsecure");
  a_reset_flags: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $rose(rst_n) |-> cbe_q && ccFlag && !pv_q && !ae_q && !blank_q)
    else $error("status flags wrong after reset");

endmodule
`default_nettype wire

// ===== src/fcsp_pkg.sv
/*
  Package for the flash command, status and protection block: register
  offsets, field positions, reset values, command codes and state codes.
  Assumes a 32-bit AHB-Lite register bus with one register per word.
*/
package fcsp_pkg;

  // register byte offsets
  localparam logic [7:0] OFS_CONFIG  = 8'h00;
  localparam logic [7:0] OFS_PROTECT = 8'h04;
  localparam logic [7:0] OFS_STATUS  = 8'h08;
  localparam logic [7:0] OFS_COMMAND = 8'h0C;
  localparam logic [7:0] OFS_RATIO   = 8'h10;
  localparam logic [7:0] OFS_ADDR    = 8'h14;
  localparam logic [7:0] OFS_DATA    = 8'h18;
  localparam logic [7:0] OFS_SECURE  = 8'h1C;

  // field positions
  localparam int CFG_KEY_BIT      = 5;
  localparam int PROT_OFF_BIT     = 0;
  localparam int ST_CBE_BIT       = 7;
  localparam int ST_CC_BIT        = 6;
  localparam int ST_PV_BIT        = 5;
  localparam int ST_AE_BIT        = 4;
  localparam int ST_BLANK_BIT     = 2;
  localparam int RATIO_PRE8_BIT   = 6;

  // config bits 7:5 live, 4:0 read zero
  localparam logic [7:0] CFG_LIVE_MASK = 8'h00E0;
  localparam logic [7:0] CFG_RESET     = 8'h0000;
  localparam logic [6:0] RATIO_RESET   = 7'h00;
  localparam logic [1:0] SEC_UNSECURED = 2'h2;
  localparam logic [1:0] SEC_RESET     = 2'h3;

  // key window
  localparam logic [15:0] KEY_WIN_LO = 16'hFFB0;
  localparam logic [15:0] KEY_WIN_HI = 16'hFFB7;

  // command codes
  localparam logic [7:0] CMD_BLANK = 8'h05;
  localparam logic [7:0] CMD_BYTE  = 8'h20;
  localparam logic [7:0] CMD_BURST = 8'h25;
  localparam logic [7:0] CMD_PAGE  = 8'h40;
  localparam logic [7:0] CMD_MASS  = 8'h41;

  // array operation ends on the flash clock pulse after this many
  localparam logic [7:0] OP_PULSES = 8'h04;

  typedef enum logic [1:0] {
    FCSP_IDLE = 2'b00,
    FCSP_RUN  = 2'b01
  } fcsp_state_t;

endpackage

// ===== verif/fcsp_core_test.sv
/*
  Self-checking bench for fcsp_core: an AHB-Lite master task, an integer
  register model and monitors on the array side, compared at each rd and at the end of each status poll.
  Assumes the package offsets and a slave that answers through hreadyout.
*/
`timescale 1ns/1ps
`default_nettype none
module fcsp_core_test;
  import fcsp_pkg::*;
  // bus side
  logic        ref_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        hsel = 1'b0;
  logic        hwrite = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0]  htrans = 2'b00;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  // array side
  logic [7:0]  nvProtectImage = 8'hA0;
  logic        arrayErased = 1'b0;
  logic        keyMatch = 1'b0;
  logic        stopEntry = 1'b0;
  logic        keyWriteStrobe, flashClkPulse, opActive, opWas;
  logic [15:0] keyWriteAddr, keyA, opAddr;
  logic [7:0]  keyWriteData, opCode, seenOp, lastOp, prot, keyD, opData;
  logic [1:0]  securityStateCode;
  // model state
  logic        ae, pv, blank, ratioSet;
  logic [31:0] v;
  int          badCount, totalChecks, ops, opCnt, keyCnt, cyc, lastP, gap, seed;
  logic [7:0]  cmds [6] = '{CMD_BLANK, CMD_BYTE, CMD_BURST, CMD_PAGE, CMD_MASS, 8'h13};
  logic [15:0] ka [4] = '{16'hFFAF, 16'hFFB0, 16'hFFB7, 16'hFFB8};

  fcsp_core fcsp_core_i (
    .ref_clk(ref_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .nvProtectImage(nvProtectImage),
    .arrayErased(arrayErased), .keyMatch(keyMatch), .stopEntry(stopEntry),
    .keyWriteStrobe(keyWriteStrobe), .keyWriteAddr(keyWriteAddr),
    .keyWriteData(keyWriteData), .flashClkPulse(flashClkPulse), .opActive(opActive),
    .opCode(opCode), .opAddr(opAddr), .opData(opData), .securityStateCode(securityStateCode));

  always #5 ref_clk = ~ref_clk;

  // monitors: operation starts, key strobes, flash clock spacing
  always @(posedge ref_clk) begin
    cyc++;
    if (opActive === 1'b1 && opWas !== 1'b1) begin
      opCnt++;
      seenOp = opCode;
    end
    opWas = opActive;
    if (keyWriteStrobe === 1'b1) begin
      keyCnt++;
      keyA = keyWriteAddr;
      keyD = keyWriteData;
    end
    if (flashClkPulse === 1'b1) begin
      gap = cyc - lastP;
      lastP = cyc;
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    totalChecks++;
    if (seen !== exp) begin
      badCount++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // one single transfer; holds each phase until hready is sampled high
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    @(posedge ref_clk);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, a};
    htrans <= 2'b10;
    hwrite <= wr;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    logic [31:0] x;
    bus(1'b0, a, 32'h0000_0000, x);
    check(x, {24'h00_0000, e});
  endtask

  function automatic logic [7:0] st();
    return {2'b11, pv, ae, 1'b0, blank, 2'b00};
  endfunction

  // address, command, then launch; the model decides the outcome
  task automatic launch(input logic [7:0] c, input logic [15:0] a);
    wr(OFS_ADDR, {a, 16'h0000});
    wr(OFS_COMMAND, {24'h00_0000, c});
    wr(OFS_STATUS, 32'h0000_0080);
    if (!(c inside {CMD_BLANK, CMD_BYTE, CMD_BURST, CMD_PAGE, CMD_MASS}))
      ae = 1'b1;
    else if (c != CMD_BLANK && !ratioSet)
      ae = 1'b1;
    else if (c != CMD_BLANK && !prot[0] && (c == CMD_MASS || a > {prot[7:1], 9'h1FF}))
      pv = 1'b1;
    else begin
      blank = (c == CMD_BLANK) && arrayErased;
      ops++;
      lastOp = c;
    end
  endtask

  // poll until complete, then compare the whole status and started operations
  task automatic settle(input bit withOps);
    logic [31:0] x;
    repeat (60) begin
      bus(1'b0, OFS_STATUS, 32'h0000_0000, x);
      if (x[ST_CC_BIT] === 1'b1)
        break;
    end
    check(x, {24'h00_0000, st()});
    if (withOps) begin
      check(opCnt, ops);
      check(seenOp, lastOp);
    end
  endtask

  task automatic clr();
    wr(OFS_STATUS, 32'h0000_0030);
    ae = 1'b0;
    pv = 1'b0;
  endtask

  task automatic closeOut();
    $display("checks %0d mismatches %0d", totalChecks, badCount);
    if (badCount == 0 && totalChecks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    #400_000;
    badCount++;
    closeOut();
  end

  initial begin
    seed = 20;
    prot = 8'hA0;
    {ae, pv, blank, ratioSet} = 4'b0000;
    {seenOp, lastOp} = 16'h0000;
    repeat (5) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge ref_clk);
    rd(OFS_PROTECT, prot);
    rd(OFS_STATUS, st());
    rd(8'h24, 8'h00);
    wr(8'h24, 32'hFFFF_FFFF);
    rd(8'h24, 8'h00);
    check(hresp, 1'b0);
    // program before the divider is set, then the write-one clear
    launch(CMD_BYTE, 16'h1000);
    settle(1'b1);
    wr(OFS_STATUS, 32'h0000_0000);
    rd(OFS_STATUS, st());
    clr();
    rd(OFS_STATUS, st());
    // divider spacing with and without the prescaler
    wr(OFS_RATIO, 32'h0000_0002);
    ratioSet = 1'b1;
    repeat (40) @(posedge ref_clk);
    check(gap, 3);
    wr(OFS_RATIO, 32'h0000_0041);
    repeat (80) @(posedge ref_clk);
    check(gap, 16);
    rd(OFS_RATIO, 8'hC1);
    wr(OFS_RATIO, 32'h0000_0000);
    repeat (4) begin
      v = $random(seed);
      wr(OFS_CONFIG, v);
      rd(OFS_CONFIG, v[7:0] & CFG_LIVE_MASK);
    end
    wr(OFS_STATUS, 32'h0000_004F);
    rd(OFS_STATUS, st());
    // key window only while key writes are enabled
    wr(OFS_CONFIG, 32'h0000_0000);
    wr(OFS_ADDR, 32'hFFB3_0011);
    wr(OFS_CONFIG, 32'h0000_0020);
    foreach (ka[i])
      wr(OFS_ADDR, {ka[i], 16'h003C});
    repeat (2) @(posedge ref_clk);
    check({keyCnt[7:0], keyA, keyD}, 32'h02FF_B73C);
    wr(OFS_CONFIG, 32'h0000_0000);
    check(securityStateCode, SEC_RESET);
    keyMatch <= 1'b1;
    @(posedge ref_clk);
    keyMatch <= 1'b0;
    repeat (2) @(posedge ref_clk);
    check(securityStateCode, SEC_UNSECURED);
    foreach (cmds[i]) begin
      launch(cmds[i], 16'h1000);
      settle(1'b1);
      clr();
    end
    repeat (4) begin
      v = $random(seed);
      v[0] = 1'b0;
      wr(OFS_PROTECT, v);
      if (v[7:1] < prot[7:1])
        prot[7:1] = v[7:1];
      rd(OFS_PROTECT, prot);
    end
    // last unprotected byte, then the first protected one
    v = {16'h0000, prot[7:1], 9'h1FF};
    launch(CMD_BYTE, v[15:0]);
    settle(1'b1);
    launch(CMD_BYTE, v[15:0] + 16'h0001);
    settle(1'b1);
    wr(OFS_STATUS, 32'h0000_0020);
    pv = 1'b0;
    rd(OFS_STATUS, st());
    // stop entry while an operation runs
    launch(CMD_BYTE, 16'h0100);
    stopEntry <= 1'b1;
    repeat (3) @(posedge ref_clk);
    stopEntry <= 1'b0;
    ae = 1'b1;
    settle(1'b0);
    clr();
    // a second burst while the first runs is queued without error
    wr(OFS_RATIO, 32'h0000_0003);
    // low addresses stay unprotected whatever boundary the random writes left
    launch(CMD_BURST, 16'h0100);
    launch(CMD_BURST, 16'h0101);
    rd(OFS_STATUS, 8'h00);
    settle(1'b0);
    // the queued burst continues the running operation: one start only
    ops--;
    check(opCnt, ops);
    check({opAddr, opData}, {16'h0101, 8'h00});
    // second reset: protection off, erased array
    nvProtectImage <= 8'h01;
    rst_n <= 1'b0;
    repeat (5) @(posedge ref_clk);
    rst_n <= 1'b1;
    arrayErased <= 1'b1;
    {ae, pv, blank, ratioSet} = 4'b0000;
    prot = 8'h01;
    repeat (2) @(posedge ref_clk);
    check(securityStateCode, SEC_RESET);
    wr(OFS_PROTECT, 32'h0000_0000);
    rd(OFS_PROTECT, prot);
    wr(OFS_RATIO, 32'h0000_0000);
    ratioSet = 1'b1;
    launch(CMD_BLANK, 16'h0000);
    settle(1'b1);
    check(securityStateCode, SEC_UNSECURED);
    launch(CMD_MASS, 16'h0000);
    settle(1'b1);
    closeOut();
  end
endmodule
`default_nettype wire
